// ===== logic/flash_security_defines.svh
// constants for the flash security block: offsets, field positions, encodings
// assumes byte offsets into the flash array as seen by the controller
`ifndef FLASH_SECURITY_DEFINES_SVH
`define FLASH_SECURITY_DEFINES_SVH

`define KEY_LO_OFFSET      16'h0400
`define KEY_HI_OFFSET      16'h0404
`define KEY_LAST_OFFSET    16'h0407
`define SEC_WORD_OFFSET    16'h0414
`define SEC_WORD_OFFSET_W  18'h00414
// security word fields
`define SEC_STATE_LSB      0
`define SEC_STATE_W        2
// only this code secures; an erased word (all ones) reads open
`define SEC_STATE_SECURE   2'h2
`define BACKDOOR_KEY_ENABLE_LSB          30
`define BACKDOOR_KEY_ENABLE_W            2
`define BACKDOOR_KEY_ENABLE_ENABLED      2'h2
// register indices on the plain port
`define REG_SEC_STATUS     4'h0
`define REG_MODULE_CFG     4'h1
`define REG_PROTECT        4'h2
`define REG_UNLOCK_CAUSE   4'h3
`define REG_CMD_STATUS     4'h4
// module config bits and protection register reset value
`define MCR_KEY_ACCESS_BIT_BIT     5
`define PROT_RESET         32'h0000_0000

`endif

// ===== logic/flash_security_pkg.sv
// types shared by the flash security block
// assumes flash_security_defines.svh is compiled alongside
package flash_security_pkg;
    typedef enum logic [4:0] {
        ST_LOAD_ADDR = 5'h01,
        ST_LOAD_WAIT = 5'h02,
        ST_KEY_FETCH = 5'h04,
        ST_KEY_WAIT  = 5'h08,
        ST_IDLE      = 5'h10
    } load_state_t;

    typedef enum logic [3:0] {
        BD_IDLE   = 4'h1,
        BD_OPEN   = 4'h2,
        BD_LOCKED = 4'h4,
        BD_DONE   = 4'h8
    } backdoor_state_t;
endpackage : flash_security_pkg

// ===== logic/key_store_if.sv
// carries key writes from the top into the key store
// assumes a single clock domain
`timescale 1ns/100ps
`default_nettype none
interface key_store_if;
    logic        wr_lo;
    logic        wr_hi;
    logic        clear;
    logic [31:0] wdata;
    logic [63:0] key;
    logic        have_both;
    logic        bad_key;
    modport owner (output wr_lo, output wr_hi, output clear, output wdata,
                   input key, input have_both, input bad_key);
    modport store (input wr_lo, input wr_hi, input clear, input wdata,
                   output key, output have_both, output bad_key);
endinterface : key_store_if
`default_nettype wire

// ===== logic/key_store.sv
// holds the two backdoor key words in arrival order
// assumes writes come one at a time, low word first
`timescale 1ns/100ps
`default_nettype none
module key_store (
    input  wire logic clk,
    input  wire logic rst_n,
    key_store_if.store ks
);
    logic [31:0] words [2];
    logic [1:0]  seen;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_word
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    words[g] <= 32'h0000_0000;
                    seen[g]  <= 1'b0;
                end else if (ks.clear) begin
                    seen[g] <= 1'b0;
                end else if ((g == 0) ? ks.wr_lo : (ks.wr_hi && seen[0])) begin
                    words[g] <= ks.wdata;
                    seen[g]  <= 1'b1;
                end
            end
        end
    endgenerate

    assign ks.key       = {words[0], words[1]};
    assign ks.have_both = &seen;
    // checked on the incoming word so a bad key stops the sequence at once
    assign ks.bad_key   = (ks.wr_lo || ks.wr_hi) &&
                          (ks.wdata == 32'h0000_0000 || ks.wdata == 32'hFFFF_FFFF);
endmodule : key_store
`default_nettype wire

// ===== logic/flash_security.sv
// flash security control: security word load, backdoor unlock, erase unlocks
// assumes a flash read port with one-cycle-later data and a command engine that
// reports blank check and mass erase results as one-cycle pulses
`include "flash_security_defines.svh"
`timescale 1ns/100ps
`default_nettype none
// How it works
// - fetch security word into status after reset
// - drive secured state to chip outputs
// - matching eight-byte key clears secured flag
// - backdoor allowed only with key enable set
// - no timeout between the two key writes
// - all-zero or all-one key locks backdoor
// - compare on key access clear; hold till reset
// - stored security word untouched by unlock
// - protection settings unchanged by unlock
// - full blank check pass unsecures device
// - next reset re-derives state from stored word
// - test-port mass erase then reset unsecures
// - serial-port bulk erase unsecures, clears secure bit
// - mass erase aborts with violation if protected
module flash_security
    import flash_security_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // flash array writes from the processor (key path)
    input  wire logic        flash_wr,
    input  wire logic [17:0] flash_wr_addr,
    input  wire logic [31:0] flash_wr_data,
    // flash array read port owned by this block after reset
    output logic             flash_rd,
    output logic      [17:0] flash_rd_addr,
    input  wire logic [31:0] flash_rd_data,
    // command engine events
    input  wire logic        blank_check_pass,
    input  wire logic        mass_erase_req,
    input  wire logic        mass_erase_done,
    input  wire logic        test_port_erase_done,
    input  wire logic        serial_bulk_erase_done,
    output logic             mass_erase_go,
    output logic             protection_violation_flag,
    // chip-wide security view
    output logic             chip_secured,
    output logic             load_done,
    output logic             flash_secure_status_bit
);
    logic        rst_sync1;
    logic        rst_n;
    logic [31:0] security_status_register;
    logic        secured_state_flag;
    logic [31:0] flash_module_config_register;
    logic [31:0] protect_reg;
    logic [3:0]  unlock_cause;
    logic [31:0] key_lo_flash;
    logic [63:0] key_hi_flash;
    logic        key_access_bit;
    logic        key_access_q;
    logic        key_enabled;
    logic        erase_latched;
    logic        rd_pending;
    logic [3:0]  rd_addr_q;
    logic        sec_word_cap;
    logic        key_lo_cap;
    logic        key_hi_cap;
    logic        load_idle;
    logic        key_match;
    logic [1:0]  sec_field;
    load_state_t     load_state;
    load_state_t     next_load_state;
    backdoor_state_t bd_state;
    backdoor_state_t next_bd_state;

    key_store_if ks ();

    key_store u_key_store (
        .clk   (clk),
        .rst_n (rst_n),
        .ks    (ks)
    );

    // release reset through two flops so the rest never sees a runt edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync1 <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_sync1 <= 1'b1;
            rst_n     <= rst_sync1;
        end
    end

    // read data stand one cycle after the strobe, while the address still names them
    assign sec_word_cap = load_state == ST_KEY_FETCH && flash_rd_addr == `SEC_WORD_OFFSET_W;
    assign key_lo_cap   = load_state == ST_KEY_FETCH && flash_rd_addr == {2'b00, `KEY_LO_OFFSET};
    assign key_hi_cap   = load_state == ST_KEY_FETCH && flash_rd_addr == {2'b00, `KEY_HI_OFFSET};
    assign load_idle    = load_state == ST_IDLE;
    assign sec_field    = flash_rd_data[`SEC_STATE_LSB +: `SEC_STATE_W];

    // security word and stored key fetch after every reset
    // three reads in turn: security word, key low word, key high word
    always_comb begin
        next_load_state = load_state;
        case (load_state)
            ST_LOAD_ADDR: next_load_state = ST_LOAD_WAIT;
            ST_LOAD_WAIT: next_load_state = ST_KEY_FETCH;
            ST_KEY_FETCH: begin
                if (key_hi_cap) begin
                    next_load_state = ST_IDLE;
                end else begin
                    next_load_state = ST_KEY_WAIT;
                end
            end
            ST_KEY_WAIT:  next_load_state = ST_KEY_FETCH;
            ST_IDLE:      next_load_state = ST_IDLE;
            default:      next_load_state = ST_LOAD_ADDR;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_state <= ST_LOAD_ADDR;
        end else begin
            load_state <= next_load_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_rd      <= 1'b0;
            flash_rd_addr <= 18'h00000;
        end else begin
            case (next_load_state)
                ST_LOAD_WAIT: begin
                    flash_rd      <= 1'b1;
                    flash_rd_addr <= `SEC_WORD_OFFSET_W;
                end
                ST_KEY_FETCH: begin
                    flash_rd      <= 1'b0;
                end
                ST_KEY_WAIT: begin
                    flash_rd      <= 1'b1;
                    flash_rd_addr <= sec_word_cap ? {2'b00, `KEY_LO_OFFSET} : {2'b00, `KEY_HI_OFFSET};
                end
                default: begin
                    flash_rd <= 1'b0;
                end
            endcase
        end
    end

    // stored key read back from the configuration area for the compare
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_lo_flash <= 32'h0000_0000;
            key_hi_flash <= 64'h0;
        end else begin
            if (key_lo_cap) begin
                key_lo_flash <= flash_rd_data;
            end
            if (key_hi_cap) begin
                key_hi_flash <= {key_lo_flash, flash_rd_data};
            end
        end
    end

    // the word is copied, never written back: the flash copy stays intact
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            security_status_register <= 32'h0000_0000;
        end else if (sec_word_cap) begin
            security_status_register <= flash_rd_data;
        end
    end

    assign key_enabled = security_status_register[`BACKDOOR_KEY_ENABLE_LSB +: `BACKDOOR_KEY_ENABLE_W] == `BACKDOOR_KEY_ENABLE_ENABLED;

    // module config register: key access bit lives here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_module_config_register <= 32'h0000_0000;
            protect_reg                  <= `PROT_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `REG_MODULE_CFG)
                flash_module_config_register <= reg_wdata;
            if (reg_addr == `REG_PROTECT)
                protect_reg <= reg_wdata;
        end
    end

    assign key_access_bit = flash_module_config_register[`MCR_KEY_ACCESS_BIT_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_access_q <= 1'b0;
        end else begin
            key_access_q <= key_access_bit;
        end
    end

    // key writes only reach the store while the backdoor is open
    assign ks.wdata = flash_wr_data;
    assign ks.wr_lo = (bd_state == BD_OPEN) && flash_wr &&
                      flash_wr_addr == {2'b00, `KEY_LO_OFFSET};
    assign ks.wr_hi = (bd_state == BD_OPEN) && flash_wr &&
                      flash_wr_addr == {2'b00, `KEY_HI_OFFSET};
    assign ks.clear = (bd_state != BD_OPEN);

    // no timer here: the open state waits for the access bit to clear or a bad key
    // a failed compare falls back to idle, so software may retry until locked
    always_comb begin
        next_bd_state = bd_state;
        case (bd_state)
            BD_IDLE: begin
                if (key_access_bit && !key_access_q && key_enabled && load_state == ST_IDLE)
                    next_bd_state = BD_OPEN;
            end
            BD_OPEN: begin
                if (ks.bad_key)
                    next_bd_state = BD_LOCKED;
                else if (!key_access_bit)
                    next_bd_state = BD_DONE;
            end
            BD_DONE:   next_bd_state = BD_IDLE;
            BD_LOCKED: next_bd_state = BD_LOCKED;
            default:   next_bd_state = BD_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bd_state <= BD_IDLE;
        end else begin
            bd_state <= next_bd_state;
        end
    end

    // a key counts only with both words in and the enable still set
    assign key_match = bd_state == BD_DONE && ks.have_both && key_enabled &&
                       ks.key == key_hi_flash;

    // secured flag; once cleared it stays clear until reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            secured_state_flag <= 1'b1;
        end else if (sec_word_cap) begin
            secured_state_flag <= sec_field == `SEC_STATE_SECURE;
        end else if (load_idle) begin
            if (key_match) begin
                secured_state_flag <= 1'b0;
            end
            if (blank_check_pass) begin
                secured_state_flag <= 1'b0;
            end
            if (serial_bulk_erase_done) begin
                secured_state_flag <= 1'b0;
            end
        end
    end

    // which path opened the chip, kept for software until reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_cause <= 4'h0;
        end else if (load_idle) begin
            if (key_match)
                unlock_cause[0] <= 1'b1;
            if (blank_check_pass)
                unlock_cause[1] <= 1'b1;
            if (serial_bulk_erase_done)
                unlock_cause[3] <= 1'b1;
        end
    end

    // test-port erase is noted; the reset that follows reads an erased word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            erase_latched <= 1'b0;
        end else if (test_port_erase_done || mass_erase_done) begin
            erase_latched <= 1'b1;
        end
    end

    // mass erase refused while any sector protection is on; protection untouched by unlock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mass_erase_go             <= 1'b0;
            protection_violation_flag <= 1'b0;
        end else begin
            mass_erase_go <= mass_erase_req && (protect_reg == 32'h0000_0000);
            if (mass_erase_req && protect_reg != 32'h0000_0000)
                protection_violation_flag <= 1'b1;
            else if (reg_wr && reg_addr == `REG_CMD_STATUS && reg_wdata[0])
                protection_violation_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_secured            <= 1'b1;
            flash_secure_status_bit <= 1'b1;
            load_done               <= 1'b0;
        end else begin
            // report secured until the load settles, so no unit sees a stale open state
            chip_secured            <= secured_state_flag || !load_idle;
            flash_secure_status_bit <= secured_state_flag || !load_idle;
            load_done               <= load_idle;
        end
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pending <= 1'b0;
            rd_addr_q  <= 4'h0;
        end else begin
            rd_pending <= reg_rd;
            rd_addr_q  <= reg_addr;
        end
    end

    always_comb begin
        reg_rdata = 32'h0000_0000;
        if (rd_pending) begin
            case (rd_addr_q)
                `REG_SEC_STATUS:   reg_rdata = {security_status_register[31:1], secured_state_flag};
                `REG_MODULE_CFG:   reg_rdata = flash_module_config_register;
                `REG_PROTECT:      reg_rdata = protect_reg;
                `REG_UNLOCK_CAUSE: reg_rdata = {27'h0, erase_latched, unlock_cause};
                `REG_CMD_STATUS:   reg_rdata = {28'h0, bd_state == BD_LOCKED, bd_state == BD_OPEN,
                                                load_state == ST_IDLE, protection_violation_flag};
                default:           reg_rdata = 32'h0000_0000;
            endcase
        end
    end
endmodule : flash_security
`default_nettype wire

// ===== testbench/flash_array_model.sv
// flash array model: answers the security block's reads from a small map
// assumes read data is wanted in the cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
    input  wire logic        clk,
    input  wire logic        flash_rd,
    input  wire logic [17:0] flash_rd_addr,
    input  wire logic [31:0] sec_word,
    input  wire logic [31:0] key_lo,
    input  wire logic [31:0] key_hi,
    output logic      [31:0] flash_rd_data
);
    logic [31:0] last = 32'h0;
    logic        vld  = 1'b0;
    always @(posedge clk) begin
        vld <= flash_rd;
        if (flash_rd) begin
            case (flash_rd_addr)
                18'h00400: last <= key_lo;
                18'h00404: last <= key_hi;
                18'h00414: last <= sec_word;
                default:   last <= 32'hFFFF_FFFF;
            endcase
        end
    end
    // outside the answer cycle the bus shows the inverse, so a late sample cannot pass
    assign flash_rd_data = vld ? last : ~last;
endmodule : flash_array_model
`default_nettype wire

// ===== testbench/flash_security_monitor.sv
// checker for the flash security block, watching its top ports only
// assumes event inputs are one-cycle pulses
`include "flash_security_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module flash_security_monitor (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        blank_check_pass,
    input wire logic        mass_erase_req,
    input wire logic        serial_bulk_erase_done,
    input wire logic        mass_erase_go,
    input wire logic        protection_violation_flag,
    input wire logic        chip_secured,
    input wire logic        load_done,
    input wire logic        flash_secure_status_bit
);
    logic prot_nz;
    logic key_clr;
    assign key_clr = reg_wr && reg_addr == `REG_MODULE_CFG && !reg_wdata[`MCR_KEY_ACCESS_BIT_BIT];
    // shadow of the protection register, so mass erase can be judged from outside
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prot_nz <= 1'b0;
        end else if (reg_wr && reg_addr == `REG_PROTECT) begin
            prot_nz <= |reg_wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_load_first; !load_done |-> chip_secured; endproperty
    a_load_first: assert property (p_load_first) else $error("secured flag low before load");
    property p_mirror; flash_secure_status_bit == chip_secured; endproperty
    a_mirror: assert property (p_mirror) else $error("security views disagree");
    property p_blank; blank_check_pass && load_done |-> ##2 !chip_secured; endproperty
    a_blank: assert property (p_blank) else $error("blank pass did not unsecure");
    property p_bulk; serial_bulk_erase_done && load_done |-> ##2 !flash_secure_status_bit; endproperty
    a_bulk: assert property (p_bulk) else $error("bulk erase did not clear secure bit");
    property p_hold; load_done && !chip_secured |=> !chip_secured; endproperty
    a_hold: assert property (p_hold) else $error("unsecured state lost before reset");
    property p_cause;
        $fell(chip_secured) && $past(load_done, 3) |->
            $past(blank_check_pass, 2) || $past(serial_bulk_erase_done, 2) || $past(key_clr, 4);
    endproperty
    a_cause: assert property (p_cause) else $error("secured flag fell with no cause");
    property p_viol; mass_erase_req && prot_nz |=> protection_violation_flag && !mass_erase_go; endproperty
    a_viol: assert property (p_viol) else $error("protected mass erase not refused");
    property p_go; mass_erase_go |-> $past(mass_erase_req) && !$past(prot_nz); endproperty
    a_go: assert property (p_go) else $error("mass erase launched without clean request");
    property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside answer cycle");
    c_backdoor: cover property ($past(key_clr, 4) && $fell(chip_secured));
    c_viol: cover property ($rose(protection_violation_flag));
    c_go: cover property (mass_erase_go);
endmodule : flash_security_monitor
bind flash_security flash_security_monitor mon (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .blank_check_pass, .mass_erase_req,
    .serial_bulk_erase_done, .mass_erase_go, .protection_violation_flag, .chip_secured, .load_done,
    .flash_secure_status_bit
);
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the flash security block
// assumes the flash array model answers reads one cycle later
`include "flash_security_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [31:0] SW_SEC    = 32'h8000_0002;
    localparam logic [31:0] SW_NOKEY  = 32'h0000_0002;
    localparam logic [31:0] SW_ERASED = 32'hFFFF_FFFF;
    localparam logic [31:0] KLO      = 32'h1234_5678;
    localparam logic [31:0] KHI      = 32'h9ABC_DEF0;
    logic        clk           = 1'b0;
    logic        rstn          = 1'b0;
    logic [3:0]  reg_addr      = 4'h0;
    logic [31:0] reg_wdata     = 32'h0;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic        flash_wr      = 1'b0;
    logic [17:0] flash_wr_addr = 18'h0;
    logic [31:0] flash_wr_data = 32'h0;
    logic [4:0]  ev            = 5'h0;
    logic [31:0] sec_word      = SW_SEC;
    logic        go_seen       = 1'b0;
    logic [31:0] reg_rdata, flash_rd_data, v;
    logic [17:0] flash_rd_addr;
    logic        flash_rd, mass_erase_go, protection_violation_flag, chip_secured, load_done, flash_secure_status_bit;
    int          failures = 0, cmp_count = 0, cycles = 0;
    flash_security dut (
        .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_wr, .flash_wr_addr,
        .flash_wr_data, .flash_rd, .flash_rd_addr, .flash_rd_data, .blank_check_pass(ev[0]),
        .mass_erase_req(ev[1]), .mass_erase_done(ev[2]), .test_port_erase_done(ev[3]),
        .serial_bulk_erase_done(ev[4]), .mass_erase_go, .protection_violation_flag, .chip_secured,
        .load_done, .flash_secure_status_bit
    );
    flash_array_model flash (.clk, .flash_rd, .flash_rd_addr, .sec_word, .key_lo(KLO), .key_hi(KHI), .flash_rd_data);
    initial forever #12.5 clk = ~clk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cycles++;
        if (mass_erase_go === 1'b1) go_seen = 1'b1;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic fw(input logic [15:0] a, input logic [31:0] d);
        flash_wr_addr <= {2'b00, a};
        flash_wr_data <= d;
        flash_wr      <= 1'b1;
        @(posedge clk);
        flash_wr <= 1'b0;
        @(posedge clk);
    endtask : fw
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 5'h0;
        @(posedge clk);
    endtask : pulse
    task automatic boot(input logic [31:0] w);
        rstn     <= 1'b0;
        sec_word <= w;
        go_seen = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (60) if (load_done !== 1'b1) @(posedge clk);
        chk("load_done", 1, load_done);
    endtask : boot
    task automatic backdoor(input logic [31:0] lo, input logic [31:0] hi, input int gap);
        wr(`REG_MODULE_CFG, 32'h1 << `MCR_KEY_ACCESS_BIT_BIT);
        fw(`KEY_LO_OFFSET, lo);
        repeat (gap) @(posedge clk);
        fw(`KEY_HI_OFFSET, hi);
        wr(`REG_MODULE_CFG, 32'h0);
        repeat (3) @(posedge clk);
    endtask : backdoor
    initial begin
        boot(SW_SEC);
        rd(`REG_SEC_STATUS, v);
        chk("status flag", 1, v[0]);
        chk("chip_secured", 1, chip_secured);
        wr(`REG_PROTECT, 32'h0000_00F0);
        backdoor(KLO, KHI, 7);
        chk("chip_secured", 0, chip_secured);
        rd(`REG_SEC_STATUS, v);
        chk("status flag", 0, v[0]);
        rd(`REG_PROTECT, v);
        chk("protection", 32'h0000_00F0, v);
        rd(`REG_UNLOCK_CAUSE, v);
        chk("unlock cause", 32'h1, v);
        rd(4'h5, v);
        chk("unmapped", 0, v);
        boot(SW_SEC);
        chk("chip_secured", 1, chip_secured);
        $display("test backdoor done");
        for (int i = 0; i < 4; i++) begin
            boot(i == 0 ? SW_NOKEY : SW_SEC);
            backdoor(i > 1 ? {32{i[0]}} : KLO, i == 1 ? ~KHI : KHI, 2);
            if (i > 1) backdoor(KLO, KHI, 0);
            chk("refused", 1, chip_secured);
            rd(`REG_CMD_STATUS, v);
            chk("cmd status", i > 1 ? 32'hA : 32'h2, v);
        end
        $display("test refusals done");
        boot(SW_SEC);
        pulse(0);
        repeat (2) @(posedge clk);
        chk("blank unlock", 0, chip_secured);
        rd(`REG_UNLOCK_CAUSE, v);
        chk("blank cause", 32'h2, v);
        boot(SW_SEC);
        chk("blank reset", 1, chip_secured);
        wr(`REG_PROTECT, 32'h1);
        pulse(1);
        chk("violation", 1, protection_violation_flag);
        chk("no launch", 0, go_seen);
        wr(`REG_CMD_STATUS, 32'h1);
        wr(`REG_PROTECT, 32'h0);
        chk("violation cleared", 0, protection_violation_flag);
        pulse(1);
        pulse(2);
        chk("launch", 1, go_seen);
        pulse(4);
        repeat (2) @(posedge clk);
        chk("secure bit", 0, flash_secure_status_bit);
        rd(`REG_UNLOCK_CAUSE, v);
        chk("erase cause", 32'h18, v);
        pulse(3);
        boot(SW_ERASED);
        chk("erased word", 0, chip_secured);
        $display("test erase paths done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
